// [hdl/pdn_pkg.sv]
// Shared constants, register map and carriers of the positioning done/near detector
package pdn_pkg;
  // ==========================================================================
  // Widths
  localparam int ERR_W      = 32;
  localparam int SPD_W      = 32;
  localparam int THR_W      = 15;
  localparam int HOLD_W     = 15;
  localparam int ADDR_W     = 12;
  localparam int DATA_W     = 32;
  localparam int COMP_SEL_W = 3;
  localparam int PROX_SEL_W = 2;
  localparam int FUNC_W     = 2;
  localparam int IRQ_W      = 2;

  // ==========================================================================
  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_COMP_SEL   = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_COMP_THR   = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_PROX_SEL   = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_PROX_THR   = 12'h00c;
  localparam logic [ADDR_W-1:0] ADDR_HOLD_TIME  = 12'h010;
  localparam logic [ADDR_W-1:0] ADDR_DO_FUNC    = 12'h014;
  localparam logic [ADDR_W-1:0] ADDR_DO_STATE   = 12'h018;
  localparam logic [ADDR_W-1:0] ADDR_POS_ERR    = 12'h01c;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 12'h020;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR  = 12'h024;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 12'h028;

  // ==========================================================================
  // Reset values and limits
  localparam logic [COMP_SEL_W-1:0] COMP_SEL_MAX = 3'h4;
  localparam logic [THR_W-1:0]      RST_COMP_THR = 15'h000a;
  localparam logic [THR_W-1:0]      RST_PROX_THR = 15'h0064;
  localparam logic [HOLD_W-1:0]     RST_HOLD     = 15'h000a;
  localparam int                    IRQ_COMPLETE = 0;
  localparam int                    IRQ_NEAR     = 1;

  // ==========================================================================
  // Timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int MS_NS           = 1000000;
  localparam int MS_CYCLES_DFLT  = MS_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Types
  typedef enum logic [COMP_SEL_W-1:0] {
    PDN_COND_LEVEL   = 3'b000,
    PDN_COND_RAW     = 3'b001,
    PDN_COND_FILT    = 3'b010,
    PDN_COND_LATCH   = 3'b011,
    PDN_COND_SEGMENT = 3'b100
  } pdn_cond_e;

  typedef enum logic [FUNC_W-1:0] {
    PDN_DO_OFF      = 2'b00,
    PDN_DO_COMPLETE = 2'b01,
    PDN_DO_NEAR     = 2'b10,
    PDN_DO_RSVD     = 2'b11
  } pdn_func_e;

  typedef struct packed {
    logic signed [ERR_W-1:0] position_error_value;
    logic signed [SPD_W-1:0] raw_speed_command;
    logic signed [SPD_W-1:0] filtered_speed_command;
    logic                    segments_sent;
    logic                    servo_running;
    logic                    position_mode;
  } pdn_motion_s;
endpackage

// [hdl/pdn_hold.sv]
// Hold timer: reports a condition that has stood uninterrupted for a number of milliseconds
`timescale 1ns/1ps
module pdn_hold #(
  parameter int unsigned MS_CYCLES = pdn_pkg::MS_CYCLES_DFLT
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        cond,
  input  wire logic [pdn_pkg::HOLD_W-1:0]  hold_ms,
  output logic                             met
);
  localparam int CW = (MS_CYCLES < 2) ? 1 : $clog2(MS_CYCLES);

  generate
    if (MS_CYCLES < 2) begin : g_chk
      $error("pdn_hold: MS_CYCLES must be at least 2");
    end
  endgenerate

  logic [CW-1:0]              cyc_q;
  logic [pdn_pkg::HOLD_W-1:0] ms_q;
  logic                       tick;

  assign tick = (cyc_q == CW'(MS_CYCLES - 1));

  // ==========================================================================
  // Millisecond prescaler, restarted with the condition so no partial ms counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_q <= '0;
    end else if (!cond || tick) begin
      cyc_q <= '0;
    end else begin
      cyc_q <= cyc_q + 1'b1;
    end
  end

  // Elapsed milliseconds; saturates so a long settle never wraps back to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_q <= '0;
    end else if (!cond) begin
      ms_q <= '0;
    end else if (tick && (ms_q != '1)) begin
      ms_q <= ms_q + 1'b1;
    end
  end

  assign met = cond && (ms_q >= hold_ms);
endmodule

// [hdl/pdn_qualify.sv]
// Output condition qualifier: selects the condition and keeps the latched indication
`timescale 1ns/1ps
module pdn_qualify (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire pdn_pkg::pdn_cond_e          cond_sel,
  input  wire logic [pdn_pkg::ERR_W-1:0]   err_abs,
  input  wire logic [pdn_pkg::THR_W-1:0]   threshold,
  input  wire logic                        raw_zero,
  input  wire logic                        filt_zero,
  input  wire logic                        segments_sent,
  input  wire logic                        enable,
  input  wire logic                        met,
  output logic                             cond,
  output logic                             ind
);
  logic below;
  logic ind_q;

  assign below = err_abs < {{(pdn_pkg::ERR_W - pdn_pkg::THR_W){1'b0}}, threshold};

  // ==========================================================================
  // Condition that feeds the hold timer
  always_comb begin
    cond = 1'b0;
    unique case (cond_sel)
      pdn_pkg::PDN_COND_LEVEL:   cond = below;
      pdn_pkg::PDN_COND_RAW:     cond = below && raw_zero;
      pdn_pkg::PDN_COND_FILT:    cond = below && filt_zero;
      pdn_pkg::PDN_COND_LATCH:   cond = below && raw_zero;
      pdn_pkg::PDN_COND_SEGMENT: cond = below && segments_sent;
      default:                   cond = 1'b0;
    endcase
    cond = cond && enable;
  end

  // Latch mode holds through error growth; only a moving command or leaving run drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ind_q <= 1'b0;
    end else if (cond_sel == pdn_pkg::PDN_COND_LATCH) begin
      ind_q <= enable && (met || (ind_q && raw_zero));
    end else begin
      ind_q <= met;
    end
  end

  assign ind = ind_q;
endmodule

// [hdl/pdn_top.sv]
// Positioning done/near detector with APB registers, output routing and interrupt
//
// Decided for this implementation: the register addresses and the APB register port.
`timescale 1ns/1ps
module pdn_top #(
  parameter int unsigned N_DO      = 4,
  parameter int unsigned MS_CYCLES = pdn_pkg::MS_CYCLES_DFLT
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [pdn_pkg::ADDR_W-1:0]  paddr,
  input  wire logic [pdn_pkg::DATA_W-1:0]  pwdata,
  output logic      [pdn_pkg::DATA_W-1:0]  prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire pdn_pkg::pdn_motion_s        motion,
  output logic      [N_DO-1:0]             do_out,
  output logic                             completion,
  output logic                             proximity,
  output logic                             irq
);
  generate
    if ((N_DO < 1) || (N_DO * pdn_pkg::FUNC_W > pdn_pkg::DATA_W)) begin : g_chk
      $error("pdn_top: N_DO out of range");
    end
  endgenerate

  // ==========================================================================
  // Registers
  logic [pdn_pkg::COMP_SEL_W-1:0] comp_sel_q;
  logic [pdn_pkg::THR_W-1:0]      comp_thr_q;
  logic [pdn_pkg::PROX_SEL_W-1:0] prox_sel_q;
  logic [pdn_pkg::THR_W-1:0]      prox_thr_q;
  logic [pdn_pkg::HOLD_W-1:0]     hold_q;
  logic [N_DO*pdn_pkg::FUNC_W-1:0] do_func_q;
  logic [N_DO-1:0]                do_q;
  logic [pdn_pkg::IRQ_W-1:0]      irq_stat_q;
  logic [pdn_pkg::IRQ_W-1:0]      irq_en_q;
  logic [pdn_pkg::DATA_W-1:0]     prdata_q;
  logic                           perr_q;
  logic                           comp_prev_q;
  logic                           prox_prev_q;

  logic                           setup;
  logic                           wr_en;
  logic [pdn_pkg::IRQ_W-1:0]      irq_clr;
  logic [pdn_pkg::IRQ_W-1:0]      irq_evt;
  logic [pdn_pkg::DATA_W-1:0]     rd_mux;
  logic                           rd_hit;

  // ==========================================================================
  // Motion inputs
  logic [pdn_pkg::ERR_W-1:0] err_u;
  logic [pdn_pkg::ERR_W-1:0] err_abs;
  logic                      raw_zero;
  logic                      filt_zero;
  logic                      run_enable;

  assign err_u      = motion.position_error_value;
  // Most negative error maps to 2^(W-1) as unsigned, so it never looks small
  assign err_abs    = err_u[pdn_pkg::ERR_W-1] ? (~err_u + 1'b1) : err_u;
  assign raw_zero   = (motion.raw_speed_command == '0);
  assign filt_zero  = (motion.filtered_speed_command == '0);
  assign run_enable = motion.position_mode && motion.servo_running;

  // ==========================================================================
  // Detection paths
  logic comp_cond;
  logic comp_met;
  logic prox_cond;
  logic prox_met;
  pdn_pkg::pdn_cond_e comp_mode;
  pdn_pkg::pdn_cond_e prox_mode;

  assign comp_mode = pdn_pkg::pdn_cond_e'(comp_sel_q);
  // Proximity field is two bits wide, so the segment mode cannot be reached
  assign prox_mode = pdn_pkg::pdn_cond_e'({1'b0, prox_sel_q});

  pdn_qualify u_comp_qual (
    .pclk          (pclk),
    .presetn       (presetn),
    .cond_sel      (comp_mode),
    .err_abs       (err_abs),
    .threshold     (comp_thr_q),
    .raw_zero      (raw_zero),
    .filt_zero     (filt_zero),
    .segments_sent (motion.segments_sent),
    .enable        (run_enable),
    .met           (comp_met),
    .cond          (comp_cond),
    .ind           (completion)
  );

  pdn_hold #(.MS_CYCLES(MS_CYCLES)) u_comp_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (comp_cond),
    .hold_ms (hold_q),
    .met     (comp_met)
  );

  pdn_qualify u_prox_qual (
    .pclk          (pclk),
    .presetn       (presetn),
    .cond_sel      (prox_mode),
    .err_abs       (err_abs),
    .threshold     (prox_thr_q),
    .raw_zero      (raw_zero),
    .filt_zero     (filt_zero),
    .segments_sent (motion.segments_sent),
    .enable        (run_enable),
    .met           (prox_met),
    .cond          (prox_cond),
    .ind           (proximity)
  );

  pdn_hold #(.MS_CYCLES(MS_CYCLES)) u_prox_hold (
    .pclk    (pclk),
    .presetn (presetn),
    .cond    (prox_cond),
    .hold_ms (hold_q),
    .met     (prox_met)
  );

  // ==========================================================================
  // Output terminal routing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_q <= '0;
    end else begin
      for (int i = 0; i < N_DO; i++) begin
        unique case (pdn_pkg::pdn_func_e'(do_func_q[i*pdn_pkg::FUNC_W +: pdn_pkg::FUNC_W]))
          pdn_pkg::PDN_DO_COMPLETE: do_q[i] <= completion;
          pdn_pkg::PDN_DO_NEAR:     do_q[i] <= proximity;
          pdn_pkg::PDN_DO_OFF:      do_q[i] <= 1'b0;
          pdn_pkg::PDN_DO_RSVD:     do_q[i] <= 1'b0;
        endcase
      end
    end
  end

  assign do_out = do_q;

  // ==========================================================================
  // APB slave: zero wait states, read data captured in the setup cycle
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && perr_q;
  assign prdata  = prdata_q;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    unique case (paddr)
      pdn_pkg::ADDR_COMP_SEL:   rd_mux = {{(pdn_pkg::DATA_W-pdn_pkg::COMP_SEL_W){1'b0}}, comp_sel_q};
      pdn_pkg::ADDR_COMP_THR:   rd_mux = {{(pdn_pkg::DATA_W-pdn_pkg::THR_W){1'b0}}, comp_thr_q};
      pdn_pkg::ADDR_PROX_SEL:   rd_mux = {{(pdn_pkg::DATA_W-pdn_pkg::PROX_SEL_W){1'b0}}, prox_sel_q};
      pdn_pkg::ADDR_PROX_THR:   rd_mux = {{(pdn_pkg::DATA_W-pdn_pkg::THR_W){1'b0}}, prox_thr_q};
      pdn_pkg::ADDR_HOLD_TIME:  rd_mux = {{(pdn_pkg::DATA_W-pdn_pkg::HOLD_W){1'b0}}, hold_q};
      pdn_pkg::ADDR_DO_FUNC:    rd_mux = pdn_pkg::DATA_W'(do_func_q);
      pdn_pkg::ADDR_DO_STATE:   rd_mux = pdn_pkg::DATA_W'(do_q);
      pdn_pkg::ADDR_POS_ERR:    rd_mux = err_u;
      pdn_pkg::ADDR_IRQ_STATUS: rd_mux = {{(pdn_pkg::DATA_W-pdn_pkg::IRQ_W){1'b0}}, irq_stat_q};
      pdn_pkg::ADDR_IRQ_CLEAR:  rd_mux = '0;
      pdn_pkg::ADDR_IRQ_ENABLE: rd_mux = {{(pdn_pkg::DATA_W-pdn_pkg::IRQ_W){1'b0}}, irq_en_q};
      default:                  rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= '0;
      perr_q   <= 1'b0;
    end else if (setup) begin
      prdata_q <= (rd_hit && !pwrite) ? rd_mux : '0;
      perr_q   <= !rd_hit;
    end
  end

  // Out-of-range selects are dropped so a running axis never sees an illegal mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_sel_q <= pdn_pkg::PDN_COND_LEVEL;
      comp_thr_q <= pdn_pkg::RST_COMP_THR;
      prox_sel_q <= '0;
      prox_thr_q <= pdn_pkg::RST_PROX_THR;
      hold_q     <= pdn_pkg::RST_HOLD;
      do_func_q  <= '0;
      irq_en_q   <= '0;
    end else if (wr_en) begin
      unique case (paddr)
        pdn_pkg::ADDR_COMP_SEL: begin
          if (pwdata <= pdn_pkg::DATA_W'(pdn_pkg::COMP_SEL_MAX)) begin
            comp_sel_q <= pwdata[pdn_pkg::COMP_SEL_W-1:0];
          end
        end
        pdn_pkg::ADDR_COMP_THR: comp_thr_q <= pwdata[pdn_pkg::THR_W-1:0];
        pdn_pkg::ADDR_PROX_SEL: begin
          if (pwdata[pdn_pkg::DATA_W-1:pdn_pkg::PROX_SEL_W] == '0) begin
            prox_sel_q <= pwdata[pdn_pkg::PROX_SEL_W-1:0];
          end
        end
        pdn_pkg::ADDR_PROX_THR:   prox_thr_q <= pwdata[pdn_pkg::THR_W-1:0];
        pdn_pkg::ADDR_HOLD_TIME:  hold_q     <= pwdata[pdn_pkg::HOLD_W-1:0];
        pdn_pkg::ADDR_DO_FUNC:    do_func_q  <= pwdata[N_DO*pdn_pkg::FUNC_W-1:0];
        pdn_pkg::ADDR_IRQ_ENABLE: irq_en_q   <= pwdata[pdn_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // Interrupts: rising indications are sticky; a set in the clear cycle wins
  assign irq_clr = (wr_en && (paddr == pdn_pkg::ADDR_IRQ_CLEAR)) ? pwdata[pdn_pkg::IRQ_W-1:0] : '0;
  assign irq_evt = {proximity && !prox_prev_q, completion && !comp_prev_q};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comp_prev_q <= 1'b0;
      prox_prev_q <= 1'b0;
      irq_stat_q  <= '0;
    end else begin
      comp_prev_q <= completion;
      prox_prev_q <= proximity;
      irq_stat_q  <= (irq_stat_q & ~irq_clr) | irq_evt;
    end
  end

  assign irq = |(irq_stat_q & irq_en_q);

  // ==========================================================================
  // Checks
  logic comp_below;
  logic prox_below;
  assign comp_below = err_abs < {{(pdn_pkg::ERR_W-pdn_pkg::THR_W){1'b0}}, comp_thr_q};
  assign prox_below = err_abs < {{(pdn_pkg::ERR_W-pdn_pkg::THR_W){1'b0}}, prox_thr_q};

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  comp_run_gate_a: assert property (completion |-> $past(run_enable))
    else $error("completion without position mode and run");
  comp_sel_range_a: assert property (comp_sel_q <= pdn_pkg::COMP_SEL_MAX)
    else $error("completion select out of range");
  comp_level_drop_a: assert property ((comp_sel_q == 3'h0) && !comp_below |=> !completion)
    else $error("mode 0 completion with large error");
  comp_raw_drop_a: assert property ((comp_sel_q == 3'h1) && !raw_zero |=> !completion)
    else $error("mode 1 completion while commanded to move");
  comp_filt_drop_a: assert property ((comp_sel_q == 3'h2) && !filt_zero |=> !completion)
    else $error("mode 2 completion with filtered command moving");
  comp_latch_keep_a: assert property ((comp_sel_q == 3'h3) && completion && raw_zero && run_enable
                                      |=> completion)
    else $error("mode 3 completion dropped while standing");
  comp_seg_wait_a: assert property ((comp_sel_q == 3'h4) && !motion.segments_sent |=> !completion)
    else $error("mode 4 completion before segments sent");
  hold_restart_a: assert property ($rose(comp_cond) && (hold_q != '0) |-> !comp_met)
    else $error("hold timer did not restart");
  near_level_drop_a: assert property ((prox_sel_q == 2'h0) && !prox_below |=> !proximity)
    else $error("mode 0 proximity with large error");
  do_route_a: assert property (do_func_q[pdn_pkg::FUNC_W-1:0] == pdn_pkg::PDN_DO_COMPLETE
                               |=> do_out[0] == $past(completion))
    else $error("terminal 0 does not follow completion");
  do_state_read_a: assert property (psel && penable && !pwrite && (paddr == pdn_pkg::ADDR_DO_STATE)
                                    |-> prdata[N_DO-1:0] == $past(do_q))
    else $error("terminal state read mismatch");
  irq_sticky_a: assert property ($rose(completion) |=> irq_stat_q[pdn_pkg::IRQ_COMPLETE])
    else $error("completion event not recorded");

  // Indications only follow a met hold time, except in latch mode, and a running axis
  comp_timed_a: assert property (completion && ($past(comp_mode) != pdn_pkg::PDN_COND_LATCH)
                                 |-> $past(comp_met))
    else $error("completion without a met hold time");
  near_timed_a: assert property (proximity && ($past(prox_mode) != pdn_pkg::PDN_COND_LATCH)
                                 |-> $past(prox_met))
    else $error("proximity without a met hold time");
  near_run_gate_a: assert property (proximity |-> $past(run_enable))
    else $error("proximity without position mode and run");
  comp_gate_drop_a: assert property (!run_enable |=> !completion)
    else $error("completion kept after leaving run");
  near_gate_drop_a: assert property (!run_enable |=> !proximity)
    else $error("proximity kept after leaving run");
  comp_level_set_a: assert property ((comp_mode == pdn_pkg::PDN_COND_LEVEL) && comp_below && run_enable
                                     && (hold_q == '0) |=> completion)
    else $error("mode 0 completion missing with zero hold");

  // Proximity modes mirror completion modes 0 to 3
  near_below_set_a: assert property ((prox_mode == pdn_pkg::PDN_COND_LEVEL) && prox_below && run_enable
                                     && (hold_q == '0) |=> proximity)
    else $error("mode 0 proximity missing with zero hold");
  near_raw_drop_a: assert property ((prox_mode == pdn_pkg::PDN_COND_RAW) && !raw_zero |=> !proximity)
    else $error("mode 1 proximity while commanded to move");

  // Register writes act at once; refused values leave the field alone
  comp_sel_keep_a: assert property (wr_en && (paddr == pdn_pkg::ADDR_COMP_SEL)
                                    && (pwdata > pdn_pkg::DATA_W'(pdn_pkg::COMP_SEL_MAX))
                                    |=> $stable(comp_sel_q))
    else $error("refused completion select was stored");
  near_sel_keep_a: assert property (wr_en && (paddr == pdn_pkg::ADDR_PROX_SEL)
                                    && (pwdata[pdn_pkg::DATA_W-1:pdn_pkg::PROX_SEL_W] != '0)
                                    |=> $stable(prox_sel_q))
    else $error("refused proximity select was stored");
  comp_thr_live_a: assert property (wr_en && (paddr == pdn_pkg::ADDR_COMP_THR)
                                    |=> comp_thr_q == $past(pwdata[pdn_pkg::THR_W-1:0]))
    else $error("completion threshold write lost");
  near_thr_live_a: assert property (wr_en && (paddr == pdn_pkg::ADDR_PROX_THR)
                                    |=> prox_thr_q == $past(pwdata[pdn_pkg::THR_W-1:0]))
    else $error("proximity threshold write lost");
  hold_live_a: assert property (wr_en && (paddr == pdn_pkg::ADDR_HOLD_TIME)
                                |=> hold_q == $past(pwdata[pdn_pkg::HOLD_W-1:0]))
    else $error("hold time write lost");

  // Terminals and interrupt
  do_off_a: assert property (do_func_q[pdn_pkg::FUNC_W-1:0] == pdn_pkg::PDN_DO_OFF |=> !do_out[0])
    else $error("switched-off terminal driven");
  irq_clear_a: assert property (wr_en && (paddr == pdn_pkg::ADDR_IRQ_CLEAR) && (irq_evt == '0)
                                && (pwdata[pdn_pkg::IRQ_W-1:0] == '1) |=> (irq_stat_q == '0))
    else $error("status survived a full clear");
  irq_gate_a: assert property ((irq_en_q == '0) |-> !irq)
    else $error("interrupt raised while disabled");

  comp_rise_c:  cover property ($rose(completion));
  prox_rise_c:  cover property ($rose(proximity));
  latch_hold_c: cover property ((comp_sel_q == 3'h3) && completion && !comp_below);
  irq_fire_c:   cover property ($rose(irq));
  seg_done_c:   cover property ((comp_mode == pdn_pkg::PDN_COND_SEGMENT) && $rose(completion));
endmodule

// [sim/pdn_host_model.sv]
// Host controller model that watches the completion terminal of the drive
`timescale 1ns/1ps
module pdn_host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic done_pin,
  output logic      done_q
);
  // ==========================================================================
  // Positioning finished
  // Only a terminal seen high ends positioning; an unknown pin never does
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_q <= 1'b0;
    end else if (done_pin === 1'b1) begin
      done_q <= 1'b1;
    end
  end
endmodule

// [sim/testbench.sv]
// Self-checking bench of the positioning done/near detector
`timescale 1ns/1ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
  localparam int unsigned MSC = 4;
  logic                       pclk;
  logic                       presetn;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [pdn_pkg::ADDR_W-1:0] paddr;
  logic [pdn_pkg::DATA_W-1:0] pwdata;
  logic [pdn_pkg::DATA_W-1:0] prdata;
  logic                       pready;
  logic                       pslverr;
  pdn_pkg::pdn_motion_s       motion;
  logic [3:0]                 do_out;
  logic                       completion;
  logic                       proximity;
  logic                       irq;
  logic                       host_done;
  logic [pdn_pkg::DATA_W-1:0] rd;
  logic                       last_err;
  int                         fail_count;
  int                         checks;

  pdn_top #(.N_DO(4), .MS_CYCLES(MSC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motion(motion), .do_out(do_out), .completion(completion), .proximity(proximity), .irq(irq)
  );

  pdn_host_model i_host (.pclk(pclk), .presetn(presetn), .done_pin(do_out[0]), .done_q(host_done));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // ==========================================================================
  // Bus and stimulus tasks
  task automatic apb(input logic wr, input logic [pdn_pkg::ADDR_W-1:0] a, input logic [pdn_pkg::DATA_W-1:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [pdn_pkg::ADDR_W-1:0] a, input logic [31:0] exp, input logic exp_err);
    apb(1'b0, a, 32'h0);
    `CHK(rd, exp)
    `CHK(last_err, exp_err)
  endtask

  task automatic setm(input logic [31:0] e, input logic [31:0] r, input logic [31:0] f, input logic seg, run);
    @(posedge pclk);
    motion <= {e, r, f, seg, run, 1'b1};
  endtask

  // Four edges cover sampling, indication and the terminal flop with zero hold
  task automatic tm(input logic [31:0] e, r, f, input logic seg, run, ec, ep);
    setm(e, r, f, seg, run);
    repeat (4) @(posedge pclk);
    #1;
    `CHK(completion, ec)
    `CHK(proximity, ep)
    `CHK(do_out, {ec, 1'b0, ep, ec})
  endtask

  task automatic finish_test();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  initial begin
    repeat (20000) @(posedge pclk);
    fail_count++;
    finish_test();
  end

  // ==========================================================================
  // Test sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    motion = '0;
    fail_count = 0;
    checks = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(pdn_pkg::ADDR_COMP_SEL, 32'h0, 1'b0);
    rdchk(pdn_pkg::ADDR_COMP_THR, 32'ha, 1'b0);
    rdchk(pdn_pkg::ADDR_PROX_SEL, 32'h0, 1'b0);
    rdchk(pdn_pkg::ADDR_PROX_THR, 32'h64, 1'b0);
    rdchk(pdn_pkg::ADDR_HOLD_TIME, 32'ha, 1'b0);
    rdchk(12'h030, 32'h0, 1'b1);
    apb(1'b1, pdn_pkg::ADDR_COMP_SEL, 32'h5);
    rdchk(pdn_pkg::ADDR_COMP_SEL, 32'h0, 1'b0);
    apb(1'b1, pdn_pkg::ADDR_PROX_SEL, 32'h4);
    rdchk(pdn_pkg::ADDR_PROX_SEL, 32'h0, 1'b0);
    apb(1'b1, pdn_pkg::ADDR_HOLD_TIME, 32'h0);
    apb(1'b1, pdn_pkg::ADDR_DO_FUNC, 32'h79);
    `CHK(host_done, 1'b0)
    `CHK(pready, 1'b1)
    tm(32'hfffffffb, 7, 7, 1'b0, 1'b1, 1'b1, 1'b1);
    tm(10, 0, 0, 1'b1, 1'b1, 1'b0, 1'b1);
    tm(32'h80000000, 0, 0, 1'b1, 1'b1, 1'b0, 1'b0);
    tm(5, 7, 7, 1'b1, 1'b0, 1'b0, 1'b0);
    rdchk(pdn_pkg::ADDR_IRQ_STATUS, 32'h3, 1'b0);
    `CHK(irq, 1'b0)
    apb(1'b1, pdn_pkg::ADDR_IRQ_ENABLE, 32'h1);
    #1;
    `CHK(irq, 1'b1)
    apb(1'b1, pdn_pkg::ADDR_IRQ_CLEAR, 32'h3);
    #1;
    `CHK(irq, 1'b0)
    rdchk(pdn_pkg::ADDR_IRQ_STATUS, 32'h0, 1'b0);
    apb(1'b1, pdn_pkg::ADDR_COMP_SEL, 32'h1);
    tm(5, 7, 0, 1'b1, 1'b1, 1'b0, 1'b1);
    tm(5, 0, 7, 1'b0, 1'b1, 1'b1, 1'b1);
    apb(1'b1, pdn_pkg::ADDR_COMP_SEL, 32'h2);
    tm(5, 0, 7, 1'b1, 1'b1, 1'b0, 1'b1);
    tm(5, 7, 0, 1'b0, 1'b1, 1'b1, 1'b1);
    apb(1'b1, pdn_pkg::ADDR_COMP_SEL, 32'h3);
    tm(5, 0, 0, 1'b0, 1'b1, 1'b1, 1'b1);
    tm(50, 0, 0, 1'b0, 1'b1, 1'b1, 1'b1);
    tm(50, 3, 0, 1'b0, 1'b1, 1'b0, 1'b1);
    apb(1'b1, pdn_pkg::ADDR_COMP_SEL, 32'h4);
    tm(5, 0, 0, 1'b0, 1'b1, 1'b0, 1'b1);
    tm(5, 0, 0, 1'b1, 1'b1, 1'b1, 1'b1);
    rdchk(pdn_pkg::ADDR_DO_STATE, 32'hb, 1'b0);
    rdchk(pdn_pkg::ADDR_POS_ERR, 32'h5, 1'b0);
    apb(1'b1, pdn_pkg::ADDR_COMP_SEL, 32'h0);
    tm(20, 1, 1, 1'b0, 1'b1, 1'b0, 1'b1);
    apb(1'b1, pdn_pkg::ADDR_COMP_THR, 32'h7fff);
    rdchk(pdn_pkg::ADDR_COMP_THR, 32'h7fff, 1'b0);
    tm(20, 1, 1, 1'b0, 1'b1, 1'b1, 1'b1);
    apb(1'b1, pdn_pkg::ADDR_COMP_THR, 32'ha);
    apb(1'b1, pdn_pkg::ADDR_PROX_SEL, 32'h1);
    tm(50, 7, 0, 1'b0, 1'b1, 1'b0, 1'b0);
    tm(50, 0, 0, 1'b0, 1'b1, 1'b0, 1'b1);
    apb(1'b1, pdn_pkg::ADDR_PROX_THR, 32'h28);
    tm(50, 0, 0, 1'b0, 1'b1, 1'b0, 1'b0);
    // Two ms hold; one dropped cycle must restart the count
    apb(1'b1, pdn_pkg::ADDR_HOLD_TIME, 32'h2);
    setm(50, 0, 0, 1'b0, 1'b1);
    setm(5, 0, 0, 1'b0, 1'b1);
    repeat (5) @(posedge pclk);
    setm(50, 0, 0, 1'b0, 1'b1);
    setm(5, 0, 0, 1'b0, 1'b1);
    repeat (7) @(posedge pclk);
    #1;
    `CHK(completion, 1'b0)
    repeat (4) @(posedge pclk);
    #1;
    `CHK(completion, 1'b1)
    `CHK(host_done, 1'b1)
    finish_test();
  end
endmodule
